// File: logic/pctp_regs.vh
// register map, field positions and codes of the pll clock and test pattern bank
`ifndef PCTP_REGS_VH
`define PCTP_REGS_VH
// register indices; byte address is four times the index
`define PCTP_IDX_PHASE     8'h6D
`define PCTP_IDX_PAT_A_LO  8'h74
`define PCTP_IDX_PAT_A_HI  8'h75
`define PCTP_IDX_PAT_B_LO  8'h76
`define PCTP_IDX_PAT_B_HI  8'h77
`define PCTP_IDX_CTRL      8'h80
`define PCTP_IDX_STAT      8'h81
`define PCTP_ADDR_W        10
`define PCTP_IDX_MSB       9
`define PCTP_IDX_LSB       2
// phase / clock gate register fields
`define PCTP_EN_CLK_BIT    5
`define PCTP_TRIM_HI_BIT   4
`define PCTP_PH_MSB        3
`define PCTP_PH_LSB        1
`define PCTP_TRIM_LO_BIT   0
// pattern lower-byte fields
`define PCTP_PLO_MSB       7
`define PCTP_PLO_LSB       2
`define PCTP_PAD_MSB       1
`define PCTP_PAD_LSB       0
// control register fields
`define PCTP_PLL_EN_BIT    0
`define PCTP_SRC_PLL_BIT   1
`define PCTP_DECIM_BIT     2
`define PCTP_TSEL_MSB      5
`define PCTP_TSEL_LSB      3
// status register fields
`define PCTP_ST_GATE_BIT   0
`define PCTP_ST_PHASE_BIT  1
`define PCTP_ST_DLY_MSB    5
`define PCTP_ST_DLY_LSB    2
// test output selector codes
`define PCTP_TSEL_NORMAL   3'h0
`define PCTP_TSEL_USER_A   3'h1
`define PCTP_TSEL_USER_B   3'h2
// phase code to vco cycles
`define PCTP_PH_CODE6      3'h6
`define PCTP_PH_CODE7      3'h7
`define PCTP_DLY_CODE6     4'hE
`define PCTP_DLY_CODE7     4'hF
`define PCTP_DLY_NONE      4'h0
`define PCTP_DLY_DEPTH     16
// reset and bus constants
`define PCTP_ZERO8         8'h00
`define PCTP_ZERO32        32'h00000000
`define PCTP_STRB_LANE0    0
`define PCTP_ZERO1         1'h0
`define PCTP_ZERO2         2'h0
`define PCTP_ZERO3         3'h0
`define PCTP_ZERO14        14'h0000
`endif

// File: logic/pctp_delay_line.v
// tapped shift line that delays the nominal data clock by a chosen count
module pctp_delay_line (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       din,
    input  wire [3:0] sel,
    output wire       dout
);
`include "pctp_regs.vh"
    wire [`PCTP_DLY_DEPTH-1:0] tap;
    assign tap[0] = din;
    // one flop per stage; tap 0 is the undelayed input
    genvar g;
    generate
        for (g = 1; g < `PCTP_DLY_DEPTH; g = g + 1) begin : g_stage
            reg st_r;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    st_r <= `PCTP_ZERO1;
                else
                    st_r <= tap[g-1];
            end
            assign tap[g] = st_r;
        end
    endgenerate
    assign dout = tap[sel];
endmodule // pctp_delay_line

// File: logic/pctp_pattern_mux.v
// chooses user pattern a, user pattern b or conversion data
module pctp_pattern_mux (
    input  wire [2:0]  tsel,
    input  wire [13:0] pat_a,
    input  wire [13:0] pat_b,
    input  wire [13:0] conv_data,
    output reg  [13:0] data_sel
);
`include "pctp_regs.vh"
    // other selector codes belong to patterns not held here
    always @* begin
        case (tsel)
            `PCTP_TSEL_USER_A: data_sel = pat_a;
            `PCTP_TSEL_USER_B: data_sel = pat_b;
            default:           data_sel = conv_data;
        endcase
    end
endmodule // pctp_pattern_mux

// File: logic/pctp_core.v
// apb register bank gating the pll clock, phasing the output clock, holding test patterns
// Notes on behaviour
// - clock gate bit passes pll clock to core
// - gate and phase act only with pll enabled
// - phase only with pll source, no decimation
// - phase shifts output clock against output data
// - pattern a bits 5:0 from low bits 7:2
// - pattern a bits 13:6 from upper byte
// - pattern b bits 5:0 from low bits 7:2
// - low two pattern bits drive unused pins
//
// The APB interface to the registers was chosen for this implementation.
module pctp_core (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [9:0]  paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    input  wire        dclk_nom,
    input  wire [13:0] conv_data,
    output reg         pready,
    output reg  [31:0] prdata,
    output reg         pslverr,
    output reg         core_clk_en,
    output reg         out_clock,
    output reg  [13:0] data_out,
    output reg  [1:0]  test_pins_out
);
`include "pctp_regs.vh"

    // true when the word address matches a register index
    function hit;
        input [`PCTP_ADDR_W-1:0] a;
        input [7:0]              idx;
        begin
            hit = (a[`PCTP_IDX_MSB:`PCTP_IDX_LSB] == idx);
        end
    endfunction

    // any register of the bank at this address
    function mapped;
        input [`PCTP_ADDR_W-1:0] a;
        begin
            mapped = hit(a, `PCTP_IDX_PHASE)    |
                     hit(a, `PCTP_IDX_PAT_A_LO) |
                     hit(a, `PCTP_IDX_PAT_A_HI) |
                     hit(a, `PCTP_IDX_PAT_B_LO) |
                     hit(a, `PCTP_IDX_PAT_B_HI) |
                     hit(a, `PCTP_IDX_CTRL)     |
                     hit(a, `PCTP_IDX_STAT);
        end
    endfunction

    // phase code to vco cycles; the top two codes jump
    function [3:0] dly_cycles;
        input [2:0] code;
        begin
            case (code)
                `PCTP_PH_CODE6: dly_cycles = `PCTP_DLY_CODE6;
                `PCTP_PH_CODE7: dly_cycles = `PCTP_DLY_CODE7;
                default:        dly_cycles = {1'b0, code};
            endcase
        end
    endfunction

    // phase register content; bits 7:6 have no storage
    reg        en_pll_clk_r;
    reg [2:0]  out_clock_phase_sel_r;
    reg [1:0]  factory_trim_bits_r;

    // pattern bytes
    reg [7:0]  pat_a_lo_r;
    reg [7:0]  pat_a_hi_r;
    reg [7:0]  pat_b_lo_r;
    reg [7:0]  pat_b_hi_r;

    // control register: pll state, clock source, decimation, selector
    reg        pll_en_r;
    reg        src_pll_r;
    reg        decim_r;
    reg [2:0]  test_output_select_r;

    // bus phase decode
    wire       acc;
    wire       wr_go;
    wire       rd_go;
    wire       lane0;
    wire [7:0] wb;

    assign acc   = psel & penable;
    assign wr_go = acc & pready & pwrite & mapped(paddr);
    assign rd_go = acc & ~pready;
    assign lane0 = pstrb[`PCTP_STRB_LANE0];
    assign wb    = pwdata[7:0];

    // one strobe per writable register, shared by the write path
    wire       hit_phase;
    wire       hit_pa_lo;
    wire       hit_pa_hi;
    wire       hit_pb_lo;
    wire       hit_pb_hi;
    wire       hit_ctrl;
    wire       wr_lane0;

    assign hit_phase = hit(paddr, `PCTP_IDX_PHASE);
    assign hit_pa_lo = hit(paddr, `PCTP_IDX_PAT_A_LO);
    assign hit_pa_hi = hit(paddr, `PCTP_IDX_PAT_A_HI);
    assign hit_pb_lo = hit(paddr, `PCTP_IDX_PAT_B_LO);
    assign hit_pb_hi = hit(paddr, `PCTP_IDX_PAT_B_HI);
    assign hit_ctrl  = hit(paddr, `PCTP_IDX_CTRL);
    // upper byte lanes carry nothing, so lane 0 alone gates a write
    assign wr_lane0  = wr_go & lane0;

    // derived behaviour
    wire        gate_on;
    wire        phase_on;
    wire [3:0]  dly_sel;
    wire        dclk_dly;
    wire [13:0] pat_a;
    wire [13:0] pat_b;
    wire [13:0] data_sel;
    reg  [1:0]  pad_nxt;

    // clock gate needs both the gate bit and a running pll
    assign gate_on  = en_pll_clk_r & pll_en_r;

    // phase applies only on a running pll feeding the output path
    assign phase_on = pll_en_r & src_pll_r & ~decim_r;

    // ignored settings fall back to the nominal position
    assign dly_sel  = phase_on ? dly_cycles(out_clock_phase_sel_r)
                               : `PCTP_DLY_NONE;

    // fourteen-bit patterns; low pad bits stay off the data bus
    assign pat_a = {pat_a_hi_r,
                    pat_a_lo_r[`PCTP_PLO_MSB:`PCTP_PLO_LSB]};
    assign pat_b = {pat_b_hi_r,
                    pat_b_lo_r[`PCTP_PLO_MSB:`PCTP_PLO_LSB]};

    // clock delay line; data path is not delayed, so the clock
    // moves against the data
    pctp_delay_line u_dly (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (dclk_nom),
        .sel     (dly_sel),
        .dout    (dclk_dly)
    );

    // selector between user patterns and conversion data
    pctp_pattern_mux u_mux (
        .tsel      (test_output_select_r),
        .pat_a     (pat_a),
        .pat_b     (pat_b),
        .conv_data (conv_data),
        .data_sel  (data_sel)
    );

    // pad bits of the active pattern go to the unused pins only
    always @* begin
        case (test_output_select_r)
            `PCTP_TSEL_USER_A:
                pad_nxt = pat_a_lo_r[`PCTP_PAD_MSB:`PCTP_PAD_LSB];
            `PCTP_TSEL_USER_B:
                pad_nxt = pat_b_lo_r[`PCTP_PAD_MSB:`PCTP_PAD_LSB];
            default:
                pad_nxt = `PCTP_ZERO2;
        endcase
    end

    // apb answer: one wait cycle, so every access is two edges long
    reg        pready_nxt;
    reg        pslverr_nxt;
    always @* begin
        pready_nxt  = acc & ~pready;
        pslverr_nxt = acc & ~pready & ~mapped(paddr);
    end

    // answer flops; both are single-cycle pulses
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= `PCTP_ZERO1;
            pslverr <= `PCTP_ZERO1;
        end else begin
            pready  <= pready_nxt;
            pslverr <= pslverr_nxt;
        end
    end

    // next values of the writable fields; each holds unless hit
    reg        en_pll_clk_nxt;
    reg [2:0]  out_clock_phase_sel_nxt;
    reg [1:0]  factory_trim_bits_nxt;
    reg [7:0]  pat_a_lo_nxt;
    reg [7:0]  pat_a_hi_nxt;
    reg [7:0]  pat_b_lo_nxt;
    reg [7:0]  pat_b_hi_nxt;
    reg        pll_en_nxt;
    reg        src_pll_nxt;
    reg        decim_nxt;
    reg [2:0]  test_output_select_nxt;

    // status is read only, writes there are dropped quietly
    always @* begin
        en_pll_clk_nxt          = en_pll_clk_r;
        out_clock_phase_sel_nxt = out_clock_phase_sel_r;
        factory_trim_bits_nxt   = factory_trim_bits_r;
        pat_a_lo_nxt            = pat_a_lo_r;
        pat_a_hi_nxt            = pat_a_hi_r;
        pat_b_lo_nxt            = pat_b_lo_r;
        pat_b_hi_nxt            = pat_b_hi_r;
        pll_en_nxt              = pll_en_r;
        src_pll_nxt             = src_pll_r;
        decim_nxt               = decim_r;
        test_output_select_nxt  = test_output_select_r;
        if (wr_lane0 & hit_phase) begin
            // bits 7:6 have no storage, so writes to them vanish
            en_pll_clk_nxt          = wb[`PCTP_EN_CLK_BIT];
            out_clock_phase_sel_nxt = wb[`PCTP_PH_MSB:`PCTP_PH_LSB];
            factory_trim_bits_nxt   = {wb[`PCTP_TRIM_HI_BIT],
                                       wb[`PCTP_TRIM_LO_BIT]};
        end
        // pad bits are stored as written; host keeps them zero
        if (wr_lane0 & hit_pa_lo) begin
            pat_a_lo_nxt = wb;
        end
        if (wr_lane0 & hit_pa_hi) begin
            pat_a_hi_nxt = wb;
        end
        if (wr_lane0 & hit_pb_lo) begin
            pat_b_lo_nxt = wb;
        end
        if (wr_lane0 & hit_pb_hi) begin
            pat_b_hi_nxt = wb;
        end
        if (wr_lane0 & hit_ctrl) begin
            pll_en_nxt             = wb[`PCTP_PLL_EN_BIT];
            src_pll_nxt            = wb[`PCTP_SRC_PLL_BIT];
            decim_nxt              = wb[`PCTP_DECIM_BIT];
            test_output_select_nxt = wb[`PCTP_TSEL_MSB:`PCTP_TSEL_LSB];
        end
    end

    // register update; a write lands at the edge that sees pready
    // reset leaves the pll clock blocked and the delay at zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_pll_clk_r          <= `PCTP_ZERO1;
            out_clock_phase_sel_r <= `PCTP_ZERO3;
            factory_trim_bits_r   <= `PCTP_ZERO2;
            pat_a_lo_r            <= `PCTP_ZERO8;
            pat_a_hi_r            <= `PCTP_ZERO8;
            pat_b_lo_r            <= `PCTP_ZERO8;
            pat_b_hi_r            <= `PCTP_ZERO8;
            pll_en_r              <= `PCTP_ZERO1;
            src_pll_r             <= `PCTP_ZERO1;
            decim_r               <= `PCTP_ZERO1;
            test_output_select_r  <= `PCTP_TSEL_NORMAL;
        end else begin
            en_pll_clk_r          <= en_pll_clk_nxt;
            out_clock_phase_sel_r <= out_clock_phase_sel_nxt;
            factory_trim_bits_r   <= factory_trim_bits_nxt;
            pat_a_lo_r            <= pat_a_lo_nxt;
            pat_a_hi_r            <= pat_a_hi_nxt;
            pat_b_lo_r            <= pat_b_lo_nxt;
            pat_b_hi_r            <= pat_b_hi_nxt;
            pll_en_r              <= pll_en_nxt;
            src_pll_r             <= src_pll_nxt;
            decim_r               <= decim_nxt;
            test_output_select_r  <= test_output_select_nxt;
        end
    end

    // read word assembly, narrow data in the low byte
    // unmapped words and unused bits read as zero
    reg [31:0] rd_nxt;
    always @* begin
        rd_nxt = `PCTP_ZERO32;
        if (hit(paddr, `PCTP_IDX_PHASE)) begin
            // top two bits read as zero
            rd_nxt[`PCTP_EN_CLK_BIT]        = en_pll_clk_r;
            rd_nxt[`PCTP_TRIM_HI_BIT]       = factory_trim_bits_r[1];
            rd_nxt[`PCTP_PH_MSB:`PCTP_PH_LSB] = out_clock_phase_sel_r;
            rd_nxt[`PCTP_TRIM_LO_BIT]       = factory_trim_bits_r[0];
        end
        if (hit(paddr, `PCTP_IDX_PAT_A_LO)) begin
            rd_nxt[7:0] = pat_a_lo_r;
        end
        if (hit(paddr, `PCTP_IDX_PAT_A_HI)) begin
            rd_nxt[7:0] = pat_a_hi_r;
        end
        if (hit(paddr, `PCTP_IDX_PAT_B_LO)) begin
            rd_nxt[7:0] = pat_b_lo_r;
        end
        if (hit(paddr, `PCTP_IDX_PAT_B_HI)) begin
            rd_nxt[7:0] = pat_b_hi_r;
        end
        if (hit(paddr, `PCTP_IDX_CTRL)) begin
            rd_nxt[`PCTP_PLL_EN_BIT]          = pll_en_r;
            rd_nxt[`PCTP_SRC_PLL_BIT]         = src_pll_r;
            rd_nxt[`PCTP_DECIM_BIT]           = decim_r;
            rd_nxt[`PCTP_TSEL_MSB:`PCTP_TSEL_LSB] = test_output_select_r;
        end
        if (hit(paddr, `PCTP_IDX_STAT)) begin
            // live state, so software sees what really applies
            rd_nxt[`PCTP_ST_GATE_BIT]  = gate_on;
            rd_nxt[`PCTP_ST_PHASE_BIT] = phase_on;
            rd_nxt[`PCTP_ST_DLY_MSB:`PCTP_ST_DLY_LSB] = dly_sel;
        end
    end

    // a write cycle leaves the last read word in place
    wire       rd_take;
    assign rd_take = rd_go & ~pwrite;

    // read data captured in the wait cycle, held until the next read
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `PCTP_ZERO32;
        end else if (rd_take) begin
            prdata <= rd_nxt;
        end
    end

    // output stage: every output leaves through a flop
    // costs a cycle of latency but keeps decode glitches off the pins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_clk_en   <= `PCTP_ZERO1;
            out_clock     <= `PCTP_ZERO1;
            data_out      <= `PCTP_ZERO14;
            test_pins_out <= `PCTP_ZERO2;
        end else begin
            core_clk_en   <= gate_on;
            out_clock     <= dclk_dly;
            data_out      <= data_sel;
            test_pins_out <= pad_nxt;
        end
    end

endmodule // pctp_core

// File: verif/pctp_core_monitor.sv
// checker for the pll clock and test pattern register bank
module pctp_core_monitor (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [9:0]  paddr,
    input wire        pready,
    input wire [31:0] prdata,
    input wire        pslverr,
    input wire        core_clk_en
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // access phase is two cycles, answer is a one-cycle pulse
    chk_ready_second: assert property ($rose(penable) && psel |=> pready) else $error("pready late");
    chk_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
    chk_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    // only the seven mapped words answer without error
    chk_err_map: assert property (pready |-> pslverr == !(paddr[9:2] inside {8'h6D, 8'h74, 8'h75,
        8'h76, 8'h77, 8'h80, 8'h81})) else $error("pslverr wrong for address");
    chk_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper read bits");
    chk_phase_top: assert property (pready && !pwrite && paddr[9:2] == 8'h6D |-> prdata[7:6] == 2'h0)
        else $error("phase top bits not zero");
    // the gate only moves two edges after a completed write
    chk_gate_rise: assert property ($rose(core_clk_en) |-> $past(pready && pwrite, 2))
        else $error("gate rose without write");
    chk_gate_fall: assert property ($fell(core_clk_en) |-> $past(pready && pwrite, 2))
        else $error("gate fell without write");
endmodule // pctp_core_monitor

bind pctp_core pctp_core_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .core_clk_en(core_clk_en));

// File: verif/pctp_host.sv
// apb host model issuing configuration transfers
module pctp_host (
    input  wire         pclk,
    input  wire         pready,
    input  wire  [31:0] prdata,
    input  wire         pslverr,
    output logic        psel,
    output logic        penable,
    output logic        pwrite,
    output logic [9:0]  paddr,
    output logic [31:0] pwdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic break_pad = 1'b0; // only the pad scenario sets this
    initial begin
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 10'h000;
        pwdata = 32'h00000000;
    end
    // one transfer, held until pready is seen at a rising edge
    task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d,
                        output logic [31:0] q, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h0, d[7:2], (i == 8'h74 || i == 8'h76) && !break_pad ? 2'b00 : d[1:0]};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (pready !== 1'b1) tb.chk("pready", 1, pready);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~paddr; // released lines must not show a stale value
        pwdata <= ~pwdata;
    endtask
endmodule // pctp_host

// File: verif/tb.sv
// self-checking bench for the pll clock and test pattern register bank
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, dclk_nom, psel, penable, pwrite, pready, pslverr, core_clk_en, out_clock;
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [13:0] conv_data, data_out, prev;
    logic [1:0]  test_pins_out;
    logic [7:0]  pa_lo, pa_hi, pb_lo, pb_hi;
    logic [7:0]  idx[4] = '{8'h6D, 8'h74, 8'h75, 8'h76};
    logic [32:0] exp_q[$];
    logic        rerr;
    int          bad_count, n_checks, cyc, n, dl;
    pctp_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .dclk_nom(dclk_nom), .conv_data(conv_data),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .core_clk_en(core_clk_en),
        .out_clock(out_clock), .data_out(data_out), .test_pins_out(test_pins_out));
    pctp_host host (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    initial begin
        pclk = 0;
        forever #2 pclk = ~pclk;
    end
    // conversion data keeps moving so the normal path is really exercised
    always @(posedge pclk) conv_data <= 14'($urandom);
    task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // read answers are matched against the oldest note
    always @(posedge pclk) if (psel && penable && pready === 1'b1 && !pwrite) chk("read", exp_q.pop_front(), {pslverr, prdata});
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            close_out;
        end
    end
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        host.xfer(1'b1, i, d, rdat, rerr);
    endtask
    task automatic rd(input logic [7:0] i, input logic [7:0] d, input logic e = 1'b0);
        exp_q.push_back({e, 24'h0, d});
        host.xfer(1'b0, i, 8'h00, rdat, rerr);
    endtask
    task automatic settle;
        repeat (2) @(posedge pclk);
        #1;
    endtask
    initial begin
        void'($urandom(32'h36f4));
        presetn = 0;
        dclk_nom = 0;
        conv_data = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        foreach (idx[k]) rd(idx[k], 8'h00);
        wr(8'h6D, 8'hFF);
        rd(8'h6D, 8'h3F);
        rd(8'h10, 8'h00, 1'b1);
        pa_lo = 8'($urandom);
        pa_hi = 8'($urandom);
        pb_lo = 8'($urandom);
        pb_hi = 8'($urandom);
        wr(8'h74, pa_lo);
        wr(8'h75, pa_hi);
        wr(8'h76, pb_lo);
        wr(8'h77, pb_hi);
        rd(8'h74, pa_lo & 8'hFC);
        rd(8'h75, pa_hi);
        rd(8'h76, pb_lo & 8'hFC);
        chk("gate_off", 0, core_clk_en);
        wr(8'h80, 8'h09);
        settle;
        chk("gate_on", 1, core_clk_en);
        chk("pat_a", {pa_hi, pa_lo[7:2]}, data_out);
        wr(8'h80, 8'h11);
        settle;
        chk("pat_b", {pb_hi, pb_lo[7:2]}, data_out);
        wr(8'h80, 8'h01);
        @(posedge pclk);
        prev = conv_data;
        #1;
        chk("conv", prev, data_out);
        // pad bits written on purpose reach only the test pins
        host.break_pad = 1'b1;
        wr(8'h74, 8'h02);
        host.break_pad = 1'b0;
        wr(8'h80, 8'h09);
        settle;
        chk("pins", 2'b10, test_pins_out);
        // every phase code; upper half alternates decimation and a non-pll source
        for (int c = 0; c < 16; c++) begin
            wr(8'h80, {5'h0, c[3] & c[0], !(c[3] & !c[0]), 1'b1});
            wr(8'h6D, {3'b001, 1'b0, c[2:0], 1'b0});
            dl = c[3] ? 0 : (c[2:0] > 5 ? c[2:0] + 8 : c[2:0]);
            rd(8'h81, {2'b00, dl[3:0], !c[3], 1'b1});
            @(posedge pclk) dclk_nom <= 1;
            @(posedge pclk) dclk_nom <= 0;
            n = 1;
            #1;
            while (out_clock !== 1'b1 && n < 40) begin
                @(posedge pclk);
                n++;
                #1;
            end
            chk("delay", 1 + dl, n);
        end
        // dropping pll enable blocks the clock and cancels the phase again
        wr(8'h80, 8'h00);
        settle;
        chk("gate_drop", 0, core_clk_en);
        rd(8'h81, 8'h00);
        // a reset in mid-run clears the gate, the phase and the patterns
        wr(8'h80, 8'h09);
        @(posedge pclk) presetn <= 1'b0;
        @(posedge pclk) presetn <= 1'b1;
        #1;
        chk("rst_gate", 0, core_clk_en);
        rd(8'h6D, 8'h00);
        rd(8'h74, 8'h00);
        close_out;
    end
endmodule // tb
